// file: hdl/pcx_port.sv
// Port C: APB register file, peripheral pin overrides and pin stages
`timescale 1ns/1ps
`include "pcx_map.svh"
module pcx_port
	import pcx_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n,
	input wire logic first_capture_pwm_unit_out,
	input wire logic first_pwm_channel_a_out,
	input wire logic first_pwm_shutdown_float,
	output logic first_capture_pwm_unit_in,
	input wire logic second_capture_pwm_unit_out,
	input wire logic second_pwm_channel_a_out,
	input wire logic second_pwm_shutdown_float,
	output logic second_capture_pwm_unit_in,
	output logic second_unit_on_port_c,
	input wire logic serial_unit_spi_clock_out,
	output logic serial_unit_spi_clock_in,
	input wire logic serial_unit_spi_data_out,
	output logic serial_unit_spi_data_in,
	input wire logic serial_unit_i2c_clock_out,
	output logic serial_unit_i2c_clock_in,
	input wire logic serial_unit_i2c_data_out,
	output logic serial_unit_i2c_data_in,
	output logic timer_external_count_in,
	output logic low_power_osc_active
);
	// --------------------------------------------------------------
	// Elaboration check
	// --------------------------------------------------------------
	if (PORT_W != 8) begin : g_chk
		$error("pcx_port supports an eight pin port only");
	end

	// The control register must hold every field the map places in it
	if (`PCX_CTL_ALT_MODE >= `PCX_CTRL_W) begin : g_chk_ctrl
		$error("pcx_port control fields do not fit the control register");
	end

	// Peripheral pin indices must name pins that exist
	if (`PCX_PIN_SDO >= PORT_W) begin : g_chk_pins
		$error("pcx_port peripheral pin index outside the port");
	end

	if (`PCX_ADDR_W != 12) begin : g_chk_addr
		$error("pcx_port decodes a twelve bit address only");
	end

	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	pcx_byte_t latch_ff, nxt_latch;
	pcx_byte_t dir_ff, nxt_dir;
	logic [`PCX_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pslverr_ff, nxt_pslverr;
	pcx_byte_t level;
	pcx_byte_t level_rd;
	pcx_byte_t periph_val;
	pcx_src_t src [PORT_W];
	logic setup_ph;
	logic wr_acc;
	logic hit_pin, hit_latch, hit_dir, hit_ctrl, hit_stat, hit_any;
	logic osc_en, spi_en, i2c_en;
	logic ccp1_en, ccp2_en, pwm1_enh, pwm2_enh;
	logic ccp2_here;
	logic on_port_ff;
	logic nxt_on_port;
	logic cap2_in_ff;
	logic nxt_cap2_in;

	// --------------------------------------------------------------
	// Control fields
	// --------------------------------------------------------------
	assign osc_en = ctrl_ff[`PCX_CTL_OSC_EN];
	assign spi_en = ctrl_ff[`PCX_CTL_SPI_EN];
	assign i2c_en = ctrl_ff[`PCX_CTL_I2C_EN];
	assign ccp1_en = ctrl_ff[`PCX_CTL_CCP1_EN];
	assign pwm1_enh = ctrl_ff[`PCX_CTL_PWM1_ENH];
	assign ccp2_en = ctrl_ff[`PCX_CTL_CCP2_EN];
	assign pwm2_enh = ctrl_ff[`PCX_CTL_PWM2_ENH];

	// Select bit one keeps the unit here; zero moves it only in alternate mode
	assign ccp2_here = ctrl_ff[`PCX_CTL_PIN_SEL] | ~ctrl_ff[`PCX_CTL_ALT_MODE]; // RULE8 RULE9

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite & ~pslverr_ff;

	always_comb begin
		hit_pin = 1'b0;
		hit_latch = 1'b0;
		hit_dir = 1'b0;
		hit_ctrl = 1'b0;
		hit_stat = 1'b0;
		if (paddr == `PCX_OFF_PIN_LEVELS) begin
			hit_pin = 1'b1;
		end else if (paddr == `PCX_OFF_OUTPUT_LATCH) begin
			hit_latch = 1'b1;
		end else if (paddr == `PCX_OFF_DIRECTION) begin
			hit_dir = 1'b1;
		end else if (paddr == `PCX_OFF_PERIPH_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (paddr == `PCX_OFF_DRIVE_STATUS) begin
			hit_stat = 1'b1;
		end
	end

	// Drive status is read-only, so a write to it is refused as well
	assign hit_any = hit_pin | hit_latch | hit_dir | hit_ctrl | (hit_stat & ~pwrite);

	// --------------------------------------------------------------
	// Pin levels as software sees them
	// --------------------------------------------------------------
	// Oscillator pins have no digital input while it runs, so they read zero
	always_comb begin
		level_rd = level; // RULE18
		if (osc_en) begin
			level_rd[`PCX_PIN_OSC_OUT] = 1'b0; // RULE10
			level_rd[`PCX_PIN_OSC_IN] = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Bus response next state
	// --------------------------------------------------------------
	// Read data is captured in the setup cycle so the access phase never waits
	always_comb begin
		nxt_prdata = prdata_ff;
		nxt_pslverr = pslverr_ff;
		if (setup_ph) begin
			nxt_pslverr = ~hit_any;
			nxt_prdata = 32'h0000_0000;
			if (!pwrite) begin
				if (hit_pin) begin
					nxt_prdata[7:0] = level_rd; // RULE18
				end else if (hit_latch) begin
					nxt_prdata[7:0] = latch_ff; // RULE4
				end else if (hit_dir) begin
					nxt_prdata[7:0] = dir_ff; // RULE6
				end else if (hit_ctrl) begin
					nxt_prdata[`PCX_CTRL_W-1:0] = ctrl_ff;
				end else if (hit_stat) begin
					nxt_prdata[7:0] = ~pin_oe_n;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// --------------------------------------------------------------
	// Register file next state
	// --------------------------------------------------------------
	// Writes land only at the access edge and never on a refused address
	always_comb begin
		nxt_latch = latch_ff;
		nxt_dir = dir_ff;
		nxt_ctrl = ctrl_ff;
		if (wr_acc) begin
			if (hit_pin && pstrb[0]) begin
				nxt_latch = pwdata[7:0]; // RULE18
			end else if (hit_latch && pstrb[0]) begin
				nxt_latch = pwdata[7:0]; // RULE4
			end else if (hit_dir && pstrb[0]) begin
				nxt_dir = pwdata[7:0]; // RULE1
			end else if (hit_ctrl) begin
				if (pstrb[0]) begin
					nxt_ctrl[7:0] = pwdata[7:0];
				end
				if (pstrb[1]) begin
					nxt_ctrl[`PCX_CTRL_W-1] = pwdata[`PCX_CTRL_W-1];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_ff <= `PCX_RST_LATCH;
			dir_ff <= `PCX_RST_DIRECTION; // RULE5
			ctrl_ff <= `PCX_RST_CTRL;
		end else begin
			latch_ff <= nxt_latch;
			dir_ff <= nxt_dir;
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Every access completes in its first access cycle
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff & psel & penable;

	// --------------------------------------------------------------
	// Pin source selection
	// --------------------------------------------------------------
	// The direction register itself is never altered by an override
	always_comb begin
		for (int i = 0; i < PORT_W; i++) begin
			src[i] = dir_ff[i] ? pcx_src_float : pcx_src_latch; // RULE2 RULE3
		end
		periph_val = 8'h00;

		// Oscillator output and input pins
		if (osc_en) begin
			src[`PCX_PIN_OSC_OUT] = pcx_src_off; // RULE10
			src[`PCX_PIN_OSC_IN] = pcx_src_off; // RULE10
		end else if (ccp2_en && ccp2_here && !dir_ff[`PCX_PIN_CCP2]) begin
			if (pwm2_enh) begin
				periph_val[`PCX_PIN_CCP2] = second_pwm_channel_a_out; // RULE12
				if (second_pwm_shutdown_float) begin
					src[`PCX_PIN_CCP2] = pcx_src_float; // RULE12
				end else begin
					src[`PCX_PIN_CCP2] = pcx_src_periph; // RULE12
				end
			end else begin
				periph_val[`PCX_PIN_CCP2] = second_capture_pwm_unit_out; // RULE11
				src[`PCX_PIN_CCP2] = pcx_src_periph; // RULE11
			end
		end

		// First capture and PWM unit
		if (ccp1_en && !dir_ff[`PCX_PIN_CCP1]) begin
			if (pwm1_enh) begin
				periph_val[`PCX_PIN_CCP1] = first_pwm_channel_a_out; // RULE12
				if (first_pwm_shutdown_float) begin
					src[`PCX_PIN_CCP1] = pcx_src_float; // RULE12
				end else begin
					src[`PCX_PIN_CCP1] = pcx_src_periph; // RULE12
				end
			end else begin
				periph_val[`PCX_PIN_CCP1] = first_capture_pwm_unit_out; // RULE11
				src[`PCX_PIN_CCP1] = pcx_src_periph; // RULE11
			end
		end

		// Serial clock; SPI wins if software enables both modes at once
		if (spi_en && !dir_ff[`PCX_PIN_SCK]) begin
			periph_val[`PCX_PIN_SCK] = serial_unit_spi_clock_out; // RULE13
			src[`PCX_PIN_SCK] = pcx_src_periph; // RULE13
		end else if (i2c_en && !spi_en && !dir_ff[`PCX_PIN_SCK]) begin
			periph_val[`PCX_PIN_SCK] = serial_unit_i2c_clock_out; // RULE14
			src[`PCX_PIN_SCK] = pcx_src_periph; // RULE14
		end

		// I2C data is open drain: pull low for zero, release for one
		if (i2c_en && !spi_en) begin
			periph_val[`PCX_PIN_SDA] = 1'b0;
			if (serial_unit_i2c_data_out) begin
				src[`PCX_PIN_SDA] = pcx_src_float; // RULE15
			end else begin
				src[`PCX_PIN_SDA] = pcx_src_periph; // RULE15
			end
		end

		// SPI data out
		if (spi_en && !dir_ff[`PCX_PIN_SDO]) begin
			periph_val[`PCX_PIN_SDO] = serial_unit_spi_data_out; // RULE17
			src[`PCX_PIN_SDO] = pcx_src_periph; // RULE17
		end
	end

	// --------------------------------------------------------------
	// Pin stages
	// --------------------------------------------------------------
	pcx_sync #(
		.W(PORT_W)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_i),
		.level(level)
	);

	for (genvar g = 0; g < PORT_W; g++) begin : g_pin
		pcx_pin_mux u_mux (
			.pclk(pclk),
			.presetn(presetn),
			.src(src[g]),
			.latch_bit(latch_ff[g]),
			.periph_bit(periph_val[g]),
			.pin_o(pin_o[g]),
			.pin_oe_n(pin_oe_n[g])
		); // RULE1
	end

	// --------------------------------------------------------------
	// Second unit routing outputs
	// --------------------------------------------------------------
	// Registered so the unit never sees a decode glitch while software rewrites
	// the control register; this costs one cycle of capture latency
	always_comb begin
		nxt_on_port = ccp2_here; // RULE8 RULE9
		nxt_cap2_in = level[`PCX_PIN_CCP2] & ccp2_here; // RULE11
	end

	// Reset follows the control reset value, whose pin select bit is one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_port_ff <= 1'b1;
			cap2_in_ff <= 1'b0;
		end else begin
			on_port_ff <= nxt_on_port;
			cap2_in_ff <= nxt_cap2_in;
		end
	end

	// --------------------------------------------------------------
	// Inputs handed to the peripherals
	// --------------------------------------------------------------
	// Levels are passed on ungated except the second unit's capture input, gated by the pin select in alternate mode; each peripheral ignores them when idle
	assign timer_external_count_in = level[`PCX_PIN_OSC_OUT];
	assign second_capture_pwm_unit_in = cap2_in_ff; // RULE11
	assign first_capture_pwm_unit_in = level[`PCX_PIN_CCP1]; // RULE11
	assign serial_unit_spi_clock_in = level[`PCX_PIN_SCK]; // RULE13
	assign serial_unit_i2c_clock_in = level[`PCX_PIN_SCK]; // RULE14
	assign serial_unit_spi_data_in = level[`PCX_PIN_SDA]; // RULE16
	assign serial_unit_i2c_data_in = level[`PCX_PIN_SDA]; // RULE15
	assign second_unit_on_port_c = on_port_ff; // RULE9
	assign low_power_osc_active = osc_en; // RULE10
endmodule

// file: hdl/pcx_map.svh
// Register map, field positions, reset values and pin indices of port C
//
// Notes on behaviour
// RULE1: Eight independent pins, each direction, latch, level.
// RULE2: Direction bit one floats the pin driver.
// RULE3: Direction bit zero drives the latch value.
// RULE4: Latch register reads back latch, not pins.
// RULE5: Reset makes every pin an input.
// RULE6: Direction register reads stored value despite overrides.
// RULE7: Peripherals force pins output or input.
// RULE8: Pin select one routes second unit to pin1.
// RULE9: Pin select zero in alternate mode moves it.
// RULE10: Oscillator enable disables digital use of pins 0,1; pin 1 still feeds the second unit's capture input.
// RULE11: Pins 1,2 compare output or capture input.
// RULE12: Channel A output overrides, floats on shutdown.
// RULE13: Pin 3 SPI clock out or in.
// RULE14: Pin 3 I2C clock out, input per unit.
// RULE15: Pin 4 I2C data driven and sampled.
// RULE16: Pin 4 SPI data sampled when input.
// RULE17: Pin 5 SPI data out when output.
// RULE18: Pin register write sets latch, read gives levels.
`ifndef PCX_MAP_SVH
`define PCX_MAP_SVH

// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define PCX_ADDR_W 12
`define PCX_OFF_PIN_LEVELS 12'h000
`define PCX_OFF_OUTPUT_LATCH 12'h004
`define PCX_OFF_DIRECTION 12'h008
`define PCX_OFF_PERIPH_CTRL 12'h00c
`define PCX_OFF_DRIVE_STATUS 12'h010

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define PCX_RST_DIRECTION 8'hff
`define PCX_RST_LATCH 8'h00
`define PCX_CTRL_W 9
`define PCX_RST_CTRL 9'h080

// --------------------------------------------------------------
// Peripheral control fields
// --------------------------------------------------------------
`define PCX_CTL_OSC_EN 0
`define PCX_CTL_SPI_EN 1
`define PCX_CTL_I2C_EN 2
`define PCX_CTL_CCP1_EN 3
`define PCX_CTL_PWM1_ENH 4
`define PCX_CTL_CCP2_EN 5
`define PCX_CTL_PWM2_ENH 6
`define PCX_CTL_PIN_SEL 7
`define PCX_CTL_ALT_MODE 8

// --------------------------------------------------------------
// Pin indices
// --------------------------------------------------------------
`define PCX_PIN_OSC_OUT 0
`define PCX_PIN_OSC_IN 1
`define PCX_PIN_CCP2 1
`define PCX_PIN_CCP1 2
`define PCX_PIN_SCK 3
`define PCX_PIN_SDA 4
`define PCX_PIN_SDO 5

`endif

// file: hdl/pcx_pkg.sv
// Types shared by the port C design files
package pcx_pkg;
	typedef logic [7:0] pcx_byte_t;
	typedef enum logic [1:0] {
		pcx_src_latch,
		pcx_src_periph,
		pcx_src_float,
		pcx_src_off
	} pcx_src_t;
endpackage

// file: hdl/pcx_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pcx_sync #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, stable_ff;
	logic [W-1:0] nxt_stable;

	if (W < 1) begin : g_chk
		$error("pcx_sync needs a positive width");
	end

	// A bit only changes once stages two and three agree
	always_comb begin
		nxt_stable = (s2_ff & ~(s2_ff ^ s3_ff)) | (stable_ff & (s2_ff ^ s3_ff));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			stable_ff <= '0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			stable_ff <= nxt_stable;
		end
	end

	assign level = stable_ff;
endmodule

// file: hdl/pcx_pin_mux.sv
// Output stage of one pin: picks its source and registers drive and enable
`timescale 1ns/1ps
module pcx_pin_mux
	import pcx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire pcx_pkg::pcx_src_t src,
	input wire logic latch_bit,
	input wire logic periph_bit,
	output logic pin_o,
	output logic pin_oe_n
);
	logic o_ff, oe_n_ff;
	logic nxt_o, nxt_oe_n;

	always_comb begin
		nxt_o = 1'b0;
		nxt_oe_n = 1'b1;
		case (src)
			pcx_src_latch: begin
				nxt_o = latch_bit; // RULE3
				nxt_oe_n = 1'b0;
			end
			pcx_src_periph: begin
				nxt_o = periph_bit; // RULE7
				nxt_oe_n = 1'b0;
			end
			pcx_src_float: begin
				nxt_oe_n = 1'b1; // RULE2
			end
			default: begin
				nxt_oe_n = 1'b1; // RULE10
			end
		endcase
	end

	// Driver starts released so nothing fights the board at power-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			o_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			o_ff <= nxt_o;
			oe_n_ff <= nxt_oe_n;
		end
	end

	assign pin_o = o_ff;
	assign pin_oe_n = oe_n_ff;
endmodule

// file: verification/pcx_pins_model.sv
// External drivers that face the port C pads
`timescale 1ns/1ps
module pcx_pins_model (
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_i
);
	// A floating pad shows the outside driver, never the last level driven
	assign pin_i = (pin_o & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// file: verification/pcx_port_properties.sv
// Concurrent checks on the port C block ports
`timescale 1ns/1ps
module pcx_port_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n,
	input wire logic first_capture_pwm_unit_out,
	input wire logic first_pwm_shutdown_float,
	input wire logic serial_unit_spi_clock_out,
	input wire logic serial_unit_spi_data_out,
	input wire logic serial_unit_i2c_data_out,
	input wire logic low_power_osc_active,
	input wire logic second_unit_on_port_c,
	input wire logic second_capture_pwm_unit_in
);
	// ----------------------------------------
	// Register shadows
	// ----------------------------------------
	logic [7:0] dir_ff, lat_ff;
	logic [8:0] ctl_ff;
	logic wr;
	assign wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_ff <= 8'hff;
			lat_ff <= 8'h00;
			ctl_ff <= 9'h080;
		end else begin
			if (wr && pstrb[0] && paddr == 12'h008) dir_ff <= pwdata[7:0];
			if (wr && pstrb[0] && paddr[11:3] == 9'h000) lat_ff <= pwdata[7:0];
			if (wr && pstrb[0] && paddr == 12'h00c) ctl_ff[7:0] <= pwdata[7:0];
			if (wr && pstrb[1] && paddr == 12'h00c) ctl_ff[8] <= pwdata[8];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	reset_inputs_a: assert property ($rose(presetn) |-> pin_oe_n == 8'hff)
		else $error("pins not inputs after reset");
	dir_float_a: assert property (pin_oe_n[7:6] == $past(dir_ff[7:6]))
		else $error("driver enable differs from direction");
	latch_drive_a: assert property (!pin_oe_n[7] |-> pin_o[7] == $past(lat_ff[7]))
		else $error("driven pin differs from latch");
	dir_read_a: assert property (
		psel && penable && !pwrite && paddr == 12'h008 |-> prdata[7:0] == dir_ff)
		else $error("direction read wrong");
	latch_read_a: assert property (
		psel && penable && !pwrite && paddr == 12'h004 |-> prdata[7:0] == lat_ff)
		else $error("latch read wrong");
	osc_off_a: assert property ($past(low_power_osc_active) |-> pin_oe_n[1:0] == 2'b11)
		else $error("oscillator pins still digital");
	spi_out_a: assert property (
		$past(ctl_ff[1] && !dir_ff[5]) |-> !pin_oe_n[5] &&
		pin_o[5] == $past(serial_unit_spi_data_out)) else $error("spi data pin");
	sck_out_a: assert property (
		$past(ctl_ff[1] && !dir_ff[3]) |-> !pin_oe_n[3] &&
		pin_o[3] == $past(serial_unit_spi_clock_out)) else $error("spi clock pin");
	i2c_data_a: assert property (
		$past(ctl_ff[2] && !ctl_ff[1]) |-> !pin_o[4] &&
		pin_oe_n[4] == $past(serial_unit_i2c_data_out)) else $error("i2c data pin");
	ccp_out_a: assert property (
		$past(ctl_ff[3] && !ctl_ff[4] && !dir_ff[2]) |-> !pin_oe_n[2] &&
		pin_o[2] == $past(first_capture_pwm_unit_out)) else $error("compare pin");
	pwm_float_a: assert property (
		$past(ctl_ff[3] && ctl_ff[4] && first_pwm_shutdown_float) |-> pin_oe_n[2])
		else $error("channel pin not floated");
	alt_pin_a: assert property (
		!second_unit_on_port_c && !$past(second_unit_on_port_c) |->
		!second_capture_pwm_unit_in) else $error("capture still on port");
endmodule
bind pcx_port pcx_port_checker chk_i (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pin_o(pin_o),
	.pin_oe_n(pin_oe_n), .first_capture_pwm_unit_out(first_capture_pwm_unit_out),
	.first_pwm_shutdown_float(first_pwm_shutdown_float),
	.serial_unit_spi_clock_out(serial_unit_spi_clock_out),
	.serial_unit_spi_data_out(serial_unit_spi_data_out),
	.serial_unit_i2c_data_out(serial_unit_i2c_data_out),
	.low_power_osc_active(low_power_osc_active),
	.second_unit_on_port_c(second_unit_on_port_c),
	.second_capture_pwm_unit_in(second_capture_pwm_unit_in)
);

// file: verification/pcx_port_tb.sv
// Self-checking bench for the port C block
`timescale 1ns/1ps
module pcx_port_tb;
	import pcx_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, err, spi_in, on_c;
	logic [7:0] pin_i, pin_o, pin_oe_n, m_oe, m_v, lvl, raw, ext = 8'h00;
	logic [6:0] fb, m_fb;
	logic [9:0] per = 10'h000;
	int n_mismatch = 0, comparisons = 0, lat, dir, ctl;
	int tbl[13] = '{'h080, 'h082, 'h084, 'h086, 'h088, 'h098, 'h081, 'h100, 'h180, 'h0a0,
		'h0e0, 'h120, 'h1a0};
	always #20 pclk = ~pclk;
	pcx_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.first_capture_pwm_unit_out(per[0]), .first_pwm_channel_a_out(per[1]),
		.first_pwm_shutdown_float(per[2]), .first_capture_pwm_unit_in(fb[2]),
		.second_capture_pwm_unit_out(per[3]), .second_pwm_channel_a_out(per[4]),
		.second_pwm_shutdown_float(per[5]), .second_capture_pwm_unit_in(fb[1]),
		.second_unit_on_port_c(on_c), .serial_unit_spi_clock_out(per[6]),
		.serial_unit_spi_clock_in(fb[3]), .serial_unit_spi_data_out(per[7]),
		.serial_unit_spi_data_in(spi_in), .serial_unit_i2c_clock_out(per[8]),
		.serial_unit_i2c_clock_in(fb[5]), .serial_unit_i2c_data_out(per[9]),
		.serial_unit_i2c_data_in(fb[4]), .timer_external_count_in(fb[0]),
		.low_power_osc_active(fb[6]));
	pcx_pins_model ext_pins (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_i(pin_i));
	// ----------------------------------------
	// Bus, compare and model tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic model();
		m_oe = ~dir[7:0];
		m_v = lat[7:0];
		if (ctl[1]) begin
			m_v[3] = per[6];
			m_v[5] = per[7];
		end else if (ctl[2]) begin
			// Data pin is open drain whatever the direction bit says
			m_v[3] = per[8];
			m_v[4] = 1'b0;
			m_oe[4] = ~per[9];
		end
		if (ctl[3]) m_v[2] = ctl[4] ? per[1] : per[0];
		if (ctl[3] && ctl[4] && per[2]) m_oe[2] = 1'b0;
		if (ctl[5] && (ctl[7] || !ctl[8])) begin
			m_v[1] = ctl[6] ? per[4] : per[3];
			if (ctl[6] && per[5]) m_oe[1] = 1'b0;
		end
		if (ctl[0]) m_oe[1:0] = 2'b00;
		raw = (m_v & m_oe) | (ext & ~m_oe);
		lvl = raw;
		if (ctl[0]) lvl[1:0] = 2'b00;
		m_fb = {ctl[0], raw[3], raw[4], raw[3], raw[2], raw[1] & (ctl[7] | ~ctl[8]), raw[0]};
	endtask
	task automatic run(input int c);
		ctl = c;
		lat = $urandom_range(255);
		dir = $urandom_range(255);
		per <= 10'($urandom);
		ext <= 8'($urandom);
		apb(1'b1, 12'h00c, ctl);
		apb(1'b1, lat[0] ? 12'h000 : 12'h004, lat);
		apb(1'b1, 12'h008, dir);
		model();
		repeat (8) @(posedge pclk);
		chk({24'h0, ~pin_oe_n}, {24'h0, m_oe});
		chk({24'h0, pin_o & m_oe}, {24'h0, m_v & m_oe});
		chk({31'h0, on_c}, {31'h0, ctl[7] | ~ctl[8]});
		chk({31'h0, spi_in}, {31'h0, lvl[4]});
		chk({25'h0, fb}, {25'h0, m_fb});
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, dir);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, lat);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, {24'h0, lvl});
		chk({31'h0, err}, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, ctl);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, {24'h0, m_oe});
	endtask
	task automatic stop_test();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		void'($urandom(93));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk({24'h0, pin_oe_n}, 32'hff);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'hff);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h010, 32'hff);
		chk({31'h0, err}, 32'h1);
		foreach (tbl[i]) run(tbl[i]);
		repeat (6) run($urandom & 'h1ff);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		stop_test();
	end
endmodule
